// file: include/pfm_pkg.sv
package pfm_pkg;
	// Geometry
	localparam int PFM_NPINS = 12;
	localparam int PFM_NIRQ  = 16;
	localparam int PFM_AW    = 8;
	localparam int PFM_SELW  = 6;
	localparam int PFM_INTERRUPT_ROUTE_BIT  = 6;
	// Pin indices
	localparam int PFM_D7 = 0;
	localparam int PFM_E0 = 1;
	localparam int PFM_E3 = 4;
	localparam int PFM_E4 = 5;
	localparam int PFM_F2 = 7;
	localparam int PFM_F3 = 8;
	// Register byte offsets
	localparam logic [7:0] PFM_OFS_PIN  = 8'h00;
	localparam logic [7:0] PFM_OFS_CSS  = 8'h30;
	localparam logic [7:0] PFM_OFS_BCR0 = 8'h34;
	localparam logic [7:0] PFM_OFS_BCR1 = 8'h38;
	localparam logic [7:0] PFM_OFS_STAT = 8'h3C;
	localparam logic [7:0] PFM_RST      = 8'h00;
	// Chip select routing fields
	localparam int PFM_CS0 = 0;
	localparam int PFM_CS1 = 2;
	localparam int PFM_CS2 = 4;
	localparam int PFM_CS3 = 6;
	// Bus control 0 bits
	localparam int PFM_ADRL = 0;
	localparam int PFM_ADRH = 1;
	localparam int PFM_BCLK = 2;
	localparam int PFM_DH   = 4;
	localparam int PFM_A20  = 5;
	// Function select codes
	localparam logic [5:0] PFM_HIZ   = 6'h00;
	localparam logic [5:0] PFM_TCLK  = 6'h02;
	localparam logic [5:0] PFM_TCLKN = 6'h04;
	localparam logic [5:0] PFM_TMRA  = 6'h05;
	localparam logic [5:0] PFM_TMRB  = 6'h06;
	localparam logic [5:0] PFM_POE   = 6'h07;
	localparam logic [5:0] PFM_SERA  = 6'h0A;
	localparam logic [5:0] PFM_SERB  = 6'h0B;
	localparam logic [5:0] PFM_CAN   = 6'h10;
	localparam logic [5:0] PFM_USBOC = 6'h11;
	localparam logic [5:0] PFM_TRG   = 6'h14;
	localparam logic [5:0] PFM_CMP   = 6'h1E;
	// Interrupt line per pin, D7 E0..E5 F2 F3 G0..G2
	localparam logic [3:0] PFM_IRQ_MAP [PFM_NPINS] = '{
		4'h8, 4'h7, 4'hF, 4'h0, 4'h2, 4'h1,
		4'h0, 4'h5, 4'hE, 4'h0, 4'h1, 4'h2};
	localparam logic [11:0] PFM_IRQ_OK = 12'hFF7;
	// Comparator per pin
	localparam logic [1:0] PFM_CMP_MAP [PFM_NPINS] = '{
		2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
		2'h0, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0};
	localparam logic [11:0] PFM_CMP_OK = 12'hF80;
	// Bus responses
	localparam logic [1:0] PFM_OKAY   = 2'b00;
	localparam logic [1:0] PFM_SLVERR = 2'b10;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} pfm_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pfm_axi_rsp_t;
endpackage

// file: logic/pfm_pin_mux.sv
// Overview of operation
// - Each pin has 6-bit function select; zero leaves the pin high impedance, except F2/F3 driving a routed strobe while the bus is active.
// - D7 codes 05,06,0A,0B feed timer0/timer6 reset, serial1/serial11 receive.
// - Interrupt bit on every pin but E2; 0 isolates pin, 1 feeds its interrupt line.
// - D7 feeds interrupt line 8; D4..D6 have no control here.
// - E0,E1,E3,E4,E5 feed lines 7,15,2,1,0.
// - F2 and F3 feed lines 5 and 14.
// - G0,G1,G2 feed lines 0,1,2.
// - E3/E4 codes 02,04,07: timer clock, inverted clock, disable request.
// - E3/E4 codes 14..17 feed PWM external triggers A..D.
// - F2,F3,G0..G2 code 1E drive a comparator result onto the pin.
// - E0 code 10 feeds CAN0 receive, 11 feeds USB overcurrent B.
// - Strobe 0 on port 9 bit 6 when 0, port C bit 0 when 1.
// - Strobe 1 field bits 3:2 picks P80, PK0, PF1 or PC2.
// - Strobe 2 field bits 5:4 picks P81, P26, else PF2.
// - Strobe 3 bit 6 picks PF3 when 0, P25 when 1.
// - Low address enable turns address 0..7 pins to bus or I/O.
// - Upper data enable turns data 8..15 pins to bus or I/O.
// - Wait route picks none, P82, PE0 or P96 for codes 00..11.
// - Bus clock force, address bit 20 enable, upper address select bits.
module pfm_pin_mux
	import pfm_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  ce,
	// Register bus
	input  wire pfm_axi_req_t          axi_req,
	output      pfm_axi_rsp_t          axi_rsp,
	// Port pins
	input  wire logic [PFM_NPINS-1:0]  pin_in,
	output      logic [PFM_NPINS-1:0]  pin_out,
	output      logic [PFM_NPINS-1:0]  pin_oe_n,
	// Wait pins outside the muxed set
	input  wire logic                  wait_pin_p82,
	input  wire logic                  wait_pin_p96,
	// On-chip sources
	input  wire logic [2:0]            comparator_result_out,
	input  wire logic [3:0]            chip_strobe_n,
	input  wire logic                  ext_bus_active,
	// Peripheral inputs
	output      logic                  timer0_reset_in,
	output      logic                  timer6_reset_in,
	output      logic                  serial1_receive,
	output      logic                  serial11_receive,
	output      logic [1:0]            ext_timer_clock_in,
	output      logic [1:0]            output_disable_request_n,
	output      logic [3:0]            pwm_ext_trigger,
	output      logic                  can0_receive,
	output      logic                  usb_overcurrent_b,
	output      logic                  wait_n,
	// External interrupt lines
	output      logic [PFM_NIRQ-1:0]   irq_line,
	// External bus pin routing
	output      logic [1:0]            strobe0_route_sel,
	output      logic [3:0]            strobe1_route_sel,
	output      logic [2:0]            strobe2_route_sel,
	output      logic [1:0]            strobe3_route_sel,
	output      logic [2:0]            wait_route_sel,
	output      logic                  low_address_out_enable,
	output      logic                  upper_data_out_enable,
	output      logic                  bus_clock_force_out,
	output      logic                  address_bit20_enable,
	output      logic                  upper_address_select
);

	logic [7:0]           pin_ctl_r [PFM_NPINS];
	logic [7:0]           css_r;
	logic [7:0]           bcr0_r;
	logic [7:0]           bcr1_r;
	logic [PFM_NPINS-1:0] pin_m_r;
	logic [PFM_NPINS-1:0] pin_s_r;
	logic [1:0]           wait_m_r;
	logic [1:0]           wait_s_r;
	logic                 aw_rdy_r;
	logic                 w_rdy_r;
	logic                 ar_rdy_r;
	logic                 bvalid_r;
	logic                 rvalid_r;
	logic                 rd_pend_r;
	logic [1:0]           bresp_r;
	logic [1:0]           rresp_r;
	logic [31:0]          rdata_r;
	logic [7:0]           awaddr_r;
	logic [7:0]           araddr_r;
	logic [7:0]           wdata_r;
	logic                 wstrb_r;
	logic                 wr_go;
	logic [PFM_NPINS-1:0] out_nxt;
	logic [PFM_NPINS-1:0] oe_n_nxt;
	logic [PFM_NIRQ-1:0]  irq_hit [PFM_NPINS];
	logic [PFM_NIRQ-1:0]  irq_nxt;
	logic [31:0]          rd_nxt;
	logic                 rd_ok;
	logic                 wr_ok;

	// Bus response struct from flops
	assign axi_rsp.awready = aw_rdy_r;
	assign axi_rsp.wready  = w_rdy_r;
	assign axi_rsp.bvalid  = bvalid_r;
	assign axi_rsp.bresp   = bresp_r;
	assign axi_rsp.arready = ar_rdy_r;
	assign axi_rsp.rvalid  = rvalid_r;
	assign axi_rsp.rdata   = rdata_r;
	assign axi_rsp.rresp   = rresp_r;

	// Two-stage sync of pin levels
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_m_r  <= '0;
			pin_s_r  <= '0;
			wait_m_r <= 2'b11;
			wait_s_r <= 2'b11;
		end else if (ce) begin
			pin_m_r  <= pin_in;
			pin_s_r  <= pin_m_r;
			wait_m_r <= {wait_pin_p96, wait_pin_p82};
			wait_s_r <= wait_m_r;
		end
	end

	// Write address and data capture, either order
	assign wr_go = !aw_rdy_r && !w_rdy_r && !bvalid_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_rdy_r <= 1'b1;
			awaddr_r <= '0;
		end else if (ce) begin
			if (aw_rdy_r && axi_req.awvalid) begin
				aw_rdy_r <= 1'b0;
				awaddr_r <= axi_req.awaddr;
			end else if (bvalid_r && axi_req.bready) begin
				aw_rdy_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			w_rdy_r <= 1'b1;
			wdata_r <= '0;
			wstrb_r <= 1'b0;
		end else if (ce) begin
			if (w_rdy_r && axi_req.wvalid) begin
				w_rdy_r <= 1'b0;
				wdata_r <= axi_req.wdata[7:0];
				wstrb_r <= axi_req.wstrb[0];
			end else if (bvalid_r && axi_req.bready) begin
				w_rdy_r <= 1'b1;
			end
		end
	end

	// Write address decode
	always_comb begin
		wr_ok = 1'b0;
		if (awaddr_r[1:0] == 2'b00) begin
			if (awaddr_r < PFM_OFS_CSS)
				wr_ok = 1'b1;
			else if (awaddr_r <= PFM_OFS_STAT)
				wr_ok = 1'b1;
		end
	end

	// Write response
	always_ff @(posedge clk) begin
		if (reset) begin
			bvalid_r <= 1'b0;
			bresp_r  <= PFM_OKAY;
		end else if (ce) begin
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_ok ? PFM_OKAY : PFM_SLVERR;
			end else if (bvalid_r && axi_req.bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Pin function registers, byte lane 0 only
	genvar gi;
	generate
		for (gi = 0; gi < PFM_NPINS; gi++) begin : g_ctl
			always_ff @(posedge clk) begin
				if (reset) begin
					pin_ctl_r[gi] <= PFM_RST;
				end else if (ce && wr_go && wstrb_r &&
					awaddr_r == PFM_OFS_PIN + 8'(4 * gi)) begin
					pin_ctl_r[gi] <= {1'b0, wdata_r[6:0]};
				end
			end
		end
	endgenerate

	// Routing and bus control registers
	always_ff @(posedge clk) begin
		if (reset) begin
			css_r  <= PFM_RST;
			bcr0_r <= PFM_RST;
			bcr1_r <= PFM_RST;
		end else if (ce && wr_go && wstrb_r) begin
			unique case (awaddr_r)
				PFM_OFS_CSS:  css_r  <= {1'b0, wdata_r[6:0]};
				PFM_OFS_BCR0: bcr0_r <= {2'b00, wdata_r[5:0]};
				PFM_OFS_BCR1: bcr1_r <= {6'h00, wdata_r[1:0]};
				default: ;
			endcase
		end
	end

	// Read decode
	always_comb begin
		rd_nxt = '0;
		rd_ok  = 1'b1;
		if (araddr_r[1:0] != 2'b00) begin
			rd_ok = 1'b0;
		end else if (araddr_r < PFM_OFS_CSS) begin
			rd_nxt[7:0] = pin_ctl_r[araddr_r[5:2]];
		end else begin
			unique case (araddr_r)
				PFM_OFS_CSS:  rd_nxt[7:0]  = css_r;
				PFM_OFS_BCR0: rd_nxt[7:0]  = bcr0_r;
				PFM_OFS_BCR1: rd_nxt[7:0]  = bcr1_r;
				PFM_OFS_STAT: rd_nxt[11:0] = pin_s_r;
				default:      rd_ok = 1'b0;
			endcase
		end
	end

	// Read channel
	always_ff @(posedge clk) begin
		if (reset) begin
			ar_rdy_r  <= 1'b1;
			araddr_r  <= '0;
			rd_pend_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= '0;
			rresp_r   <= PFM_OKAY;
		end else if (ce) begin
			if (ar_rdy_r && axi_req.arvalid) begin
				ar_rdy_r  <= 1'b0;
				araddr_r  <= axi_req.araddr;
				rd_pend_r <= 1'b1;
			end else if (rd_pend_r) begin
				rd_pend_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rdata_r   <= rd_nxt;
				rresp_r   <= rd_ok ? PFM_OKAY : PFM_SLVERR;
			end else if (rvalid_r && axi_req.rready) begin
				rvalid_r <= 1'b0;
				ar_rdy_r <= 1'b1;
			end
		end
	end

	// Per-pin output drive and interrupt contribution
	generate
		for (gi = 0; gi < PFM_NPINS; gi++) begin : g_pin
			logic [5:0] sel;
			logic       cmp_on;
			logic       cs_on;
			logic       cs_val;
			assign sel = pin_ctl_r[gi][PFM_SELW-1:0];
			// Comparator drive on capable pins
			assign cmp_on = PFM_CMP_OK[gi] && sel == PFM_CMP;
			if (gi == PFM_F2) begin : g_cs2
				assign cs_on  = css_r[PFM_CS2+1];
				assign cs_val = chip_strobe_n[2];
			end else if (gi == PFM_F3) begin : g_cs3
				assign cs_on  = !css_r[PFM_CS3];
				assign cs_val = chip_strobe_n[3];
			end else begin : g_nocs
				assign cs_on  = 1'b0;
				assign cs_val = 1'b1;
			end
			always_comb begin
				out_nxt[gi]  = 1'b0;
				oe_n_nxt[gi] = 1'b1;
				if (cmp_on) begin
					out_nxt[gi]  = comparator_result_out[PFM_CMP_MAP[gi]];
					oe_n_nxt[gi] = 1'b0;
				end else if (sel == PFM_HIZ && cs_on &&
					ext_bus_active) begin
					out_nxt[gi]  = cs_val;
					oe_n_nxt[gi] = 1'b0;
				end
			end
			// Interrupt select gates the pin onto its line
			assign irq_hit[gi] = (PFM_IRQ_OK[gi] &&
				pin_ctl_r[gi][PFM_INTERRUPT_ROUTE_BIT] && pin_s_r[gi]) ?
				PFM_NIRQ'(1) << PFM_IRQ_MAP[gi] : '0;
		end
	endgenerate

	// Merge interrupt lines
	always_comb begin
		irq_nxt = '0;
		for (int i = 0; i < PFM_NPINS; i++)
			irq_nxt = irq_nxt | irq_hit[i];
	end

	// Pin and interrupt outputs
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_out  <= '0;
			pin_oe_n <= '1;
			irq_line <= '0;
		end else if (ce) begin
			pin_out  <= out_nxt;
			pin_oe_n <= oe_n_nxt;
			irq_line <= irq_nxt;
		end
	end

	// Port D7 receive functions
	always_ff @(posedge clk) begin
		if (reset) begin
			timer0_reset_in  <= 1'b0;
			timer6_reset_in  <= 1'b0;
			serial1_receive  <= 1'b1;
			serial11_receive <= 1'b1;
		end else if (ce) begin
			timer0_reset_in  <= pin_ctl_r[PFM_D7][5:0] == PFM_TMRA &&
				pin_s_r[PFM_D7];
			timer6_reset_in  <= pin_ctl_r[PFM_D7][5:0] == PFM_TMRB &&
				pin_s_r[PFM_D7];
			serial1_receive  <= pin_ctl_r[PFM_D7][5:0] != PFM_SERA ||
				pin_s_r[PFM_D7];
			serial11_receive <= pin_ctl_r[PFM_D7][5:0] != PFM_SERB ||
				pin_s_r[PFM_D7];
		end
	end

	// Port E3/E4 timer clock, disable request, PWM triggers
	always_ff @(posedge clk) begin
		if (reset) begin
			ext_timer_clock_in       <= '0;
			output_disable_request_n <= 2'b11;
			pwm_ext_trigger          <= '0;
		end else if (ce) begin
			for (int k = 0; k < 2; k++) begin
				unique case (pin_ctl_r[PFM_E3 + k][5:0])
					PFM_TCLK:  ext_timer_clock_in[k] <=
						pin_s_r[PFM_E3 + k];
					PFM_TCLKN: ext_timer_clock_in[k] <=
						!pin_s_r[PFM_E3 + k];
					default:   ext_timer_clock_in[k] <= 1'b0;
				endcase
				output_disable_request_n[k] <=
					pin_ctl_r[PFM_E3 + k][5:0] != PFM_POE ||
					pin_s_r[PFM_E3 + k];
			end
			for (int t = 0; t < 4; t++) begin
				pwm_ext_trigger[t] <=
					(pin_ctl_r[PFM_E3][5:0] == PFM_TRG + 6'(t) &&
					pin_s_r[PFM_E3]) ||
					(pin_ctl_r[PFM_E4][5:0] == PFM_TRG + 6'(t) &&
					pin_s_r[PFM_E4]);
			end
		end
	end

	// Port E0 CAN, USB overcurrent, wait input
	always_ff @(posedge clk) begin
		if (reset) begin
			can0_receive      <= 1'b1;
			usb_overcurrent_b <= 1'b1;
			wait_n            <= 1'b1;
		end else if (ce) begin
			can0_receive      <= pin_ctl_r[PFM_E0][5:0] != PFM_CAN ||
				pin_s_r[PFM_E0];
			usb_overcurrent_b <= pin_ctl_r[PFM_E0][5:0] != PFM_USBOC ||
				pin_s_r[PFM_E0];
			unique case (bcr1_r[1:0])
				2'b00: wait_n <= 1'b1;
				2'b01: wait_n <= wait_s_r[0];
				2'b10: wait_n <= pin_s_r[PFM_E0];
				2'b11: wait_n <= wait_s_r[1];
			endcase
		end
	end

	// Strobe route selects one-hot, wait route select one-hot or all zero
	always_ff @(posedge clk) begin
		if (reset) begin
			strobe0_route_sel <= 2'b01;
			strobe1_route_sel <= 4'h1;
			strobe2_route_sel <= 3'b001;
			strobe3_route_sel <= 2'b01;
			wait_route_sel    <= 3'b000;
		end else if (ce) begin
			strobe0_route_sel <= css_r[PFM_CS0] ? 2'b10 : 2'b01;
			strobe1_route_sel <= 4'(1) << css_r[PFM_CS1 +: 2];
			strobe2_route_sel <= css_r[PFM_CS2+1] ? 3'b100 :
				(css_r[PFM_CS2] ? 3'b010 : 3'b001);
			strobe3_route_sel <= css_r[PFM_CS3] ? 2'b10 : 2'b01;
			wait_route_sel    <= (bcr1_r[1:0] == 2'b00) ? 3'b000 :
				3'(4'(1) << (bcr1_r[1:0] - 2'd1));
		end
	end

	// External bus pin enables
	always_ff @(posedge clk) begin
		if (reset) begin
			low_address_out_enable <= 1'b0;
			upper_data_out_enable  <= 1'b0;
			bus_clock_force_out    <= 1'b0;
			address_bit20_enable   <= 1'b0;
			upper_address_select   <= 1'b0;
		end else if (ce) begin
			low_address_out_enable <= bcr0_r[PFM_ADRL];
			upper_data_out_enable  <= bcr0_r[PFM_DH];
			bus_clock_force_out    <= bcr0_r[PFM_BCLK];
			address_bit20_enable   <= bcr0_r[PFM_A20];
			upper_address_select   <= bcr0_r[PFM_ADRH];
		end
	end

endmodule

// file: dv/pfm_pin_mux_assertions.sv
module pfm_pin_mux_checker
	import pfm_pkg::*;
(
	// Clock, reset and register bus
	input	wire logic			clk,
	input	wire logic			reset,
	input	wire pfm_axi_req_t		axi_req,
	input	wire pfm_axi_rsp_t		axi_rsp,
	// Pins and on-chip sources
	input	wire logic [PFM_NPINS-1:0]	pin_out,
	input	wire logic [PFM_NPINS-1:0]	pin_oe_n,
	input	wire logic [2:0]		comparator_result_out,
	// Peripheral inputs
	input	wire logic			timer0_reset_in,
	input	wire logic			timer6_reset_in,
	input	wire logic			serial1_receive,
	input	wire logic			serial11_receive,
	input	wire logic [1:0]		ext_timer_clock_in,
	input	wire logic [1:0]		output_disable_request_n,
	input	wire logic			can0_receive,
	input	wire logic			usb_overcurrent_b,
	input	wire logic			wait_n,
	// Route selects
	input	wire logic [1:0]		strobe0_route_sel,
	input	wire logic [3:0]		strobe1_route_sel,
	input	wire logic [2:0]		strobe2_route_sel,
	input	wire logic [1:0]		strobe3_route_sel,
	input	wire logic [2:0]		wait_route_sel
);
	// One clock domain for every check
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Pin drive, port input function and route select checks
	property p_hiz; &pin_oe_n[6:0]; endproperty
	property p_cmp; !pin_oe_n[9] |->
		pin_out[9] == $past(comparator_result_out[2]); endproperty
	property p_tmr; timer0_reset_in |->
		!timer6_reset_in && serial1_receive && serial11_receive; endproperty
	property p_clk; ext_timer_clock_in[0] |-> output_disable_request_n[0];
	endproperty
	property p_e0; !can0_receive |-> usb_overcurrent_b; endproperty
	property p_cs1; $onehot(strobe1_route_sel); endproperty
	property p_cs2; $onehot(strobe2_route_sel); endproperty
	property p_cs03; $onehot(strobe0_route_sel) && $onehot(strobe3_route_sel);
	endproperty
	property p_wait; $onehot0(wait_route_sel) &&
		(wait_route_sel != 3'b000 || wait_n); endproperty
	// Read handshake steps
	sequence s_ar; axi_req.arvalid && axi_rsp.arready; endsequence
	sequence s_r; axi_rsp.rvalid; endsequence
	property p_rd; s_ar |-> ##[1:3] s_r; endproperty
	property p_rhold; axi_rsp.rvalid && !axi_req.rready |=>
		axi_rsp.rvalid && $stable(axi_rsp.rdata); endproperty

	a_hiz: assert property (p_hiz)
		else $error("input-only pin driven");
	a_cmp: assert property (p_cmp)
		else $error("comparator pin value wrong");
	a_tmr: assert property (p_tmr)
		else $error("two port D7 functions at once");
	a_clk: assert property (p_clk)
		else $error("two port E3 functions at once");
	a_e0: assert property (p_e0)
		else $error("two port E0 functions at once");
	a_cs1: assert property (p_cs1)
		else $error("strobe 1 route not one-hot");
	a_cs2: assert property (p_cs2)
		else $error("strobe 2 route not one-hot");
	a_cs03: assert property (p_cs03)
		else $error("strobe 0 or 3 route not one-hot");
	a_wait: assert property (p_wait)
		else $error("wait route or idle level wrong");
	a_rd: assert property (p_rd)
		else $error("read answer late");
	a_rhold: assert property (p_rhold)
		else $error("read answer not held");
endmodule

bind pfm_pin_mux pfm_pin_mux_checker i_pfm_pin_mux_checker (.clk(clk),
	.reset(reset), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.pin_out(pin_out), .pin_oe_n(pin_oe_n),
	.comparator_result_out(comparator_result_out),
	.timer0_reset_in(timer0_reset_in), .timer6_reset_in(timer6_reset_in),
	.serial1_receive(serial1_receive), .serial11_receive(serial11_receive),
	.ext_timer_clock_in(ext_timer_clock_in),
	.output_disable_request_n(output_disable_request_n),
	.can0_receive(can0_receive), .usb_overcurrent_b(usb_overcurrent_b),
	.wait_n(wait_n), .strobe0_route_sel(strobe0_route_sel),
	.strobe1_route_sel(strobe1_route_sel),
	.strobe2_route_sel(strobe2_route_sel),
	.strobe3_route_sel(strobe3_route_sel), .wait_route_sel(wait_route_sel));

// file: dv/tb_top.sv
module tb_top
	import pfm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Stimulus and observed signals
	logic		clk, reset, ce, bus_act, p82, p96;
	pfm_axi_req_t	req;
	pfm_axi_rsp_t	rsp;
	logic [11:0]	pin_in, pin_out, pin_oe_n;
	logic [2:0]	cmp, cs2, wsel;
	logic [3:0]	stb_n, trig, cs1;
	logic [1:0]	tclk, poe_n, cs0, cs3;
	logic		t0, t6, s1, s11, can, usb, wait_n;
	logic		adrl, dh, bclk, a20, adrh;
	logic [15:0]	irq;
	logic [31:0]	d;
	logic [1:0]	r;
	logic [3:0]	strb = 4'hF;
	int		miscompares = 0;
	int		compares = 0;

	pfm_pin_mux i_pfm_pin_mux (.clk(clk), .reset(reset), .ce(ce),
		.axi_req(req), .axi_rsp(rsp), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .wait_pin_p82(p82), .wait_pin_p96(p96),
		.comparator_result_out(cmp), .chip_strobe_n(stb_n),
		.ext_bus_active(bus_act), .timer0_reset_in(t0),
		.timer6_reset_in(t6), .serial1_receive(s1),
		.serial11_receive(s11), .ext_timer_clock_in(tclk),
		.output_disable_request_n(poe_n), .pwm_ext_trigger(trig),
		.can0_receive(can), .usb_overcurrent_b(usb), .wait_n(wait_n),
		.irq_line(irq), .strobe0_route_sel(cs0), .strobe1_route_sel(cs1),
		.strobe2_route_sel(cs2), .strobe3_route_sel(cs3),
		.wait_route_sel(wsel), .low_address_out_enable(adrl),
		.upper_data_out_enable(dh), .bus_clock_force_out(bclk),
		.address_bit20_enable(a20), .upper_address_select(adrh));

	// Clock
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wrap_up();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic settle();
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		logic haw, hw, hb;
		hb = 0;
		@(posedge clk);
		req.awvalid <= 1; req.awaddr <= a; req.bready <= 1;
		req.wvalid <= 1; req.wdata <= v; req.wstrb <= strb;
		while (!hb) begin
			@(negedge clk);
			haw = req.awvalid && rsp.awready;
			hw = req.wvalid && rsp.wready;
			hb = rsp.bvalid;
			r = rsp.bresp;
			@(posedge clk);
			if (haw) req.awvalid <= 0;
			if (hw) req.wvalid <= 0;
			if (hb) req.bready <= 0;
		end
	endtask

	task automatic axi_rd(input logic [7:0] a);
		logic har, hr;
		hr = 0;
		@(posedge clk);
		req.arvalid <= 1; req.araddr <= a; req.rready <= 1;
		while (!hr) begin
			@(negedge clk);
			har = req.arvalid && rsp.arready;
			hr = rsp.rvalid;
			d = rsp.rdata;
			r = rsp.rresp;
			@(posedge clk);
			if (har) req.arvalid <= 0;
			if (hr) req.rready <= 0;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		axi_wr(a, v);
		check(r, PFM_OKAY);
		settle();
	endtask

	task automatic set_pin(input int i, input logic p);
		@(posedge clk);
		pin_in[i] <= p;
		settle();
	endtask

	// Reset levels, read-back and refused accesses
	task automatic t_regs();
		@(negedge clk);
		check(pin_oe_n, 12'hFFF);
		check({cs0, cs1, cs2, cs3, wsel}, 14'h1128);
		check({irq, s1, s11, can, usb, wait_n}, 21'h0_001F);
		for (int i = 0; i < 16; i++) begin
			axi_rd(8'(4 * i));
			check(d, 32'h0000_0000);
		end
		axi_rd(8'h40);
		check(d, 32'h0000_0000);
		check(r, PFM_SLVERR);
		axi_wr(8'h42, 32'h0000_00FF);
		check(r, PFM_SLVERR);
		wr(8'h0C, 32'h0000_00FF);
		axi_rd(8'h0C);
		check(d, 32'h0000_007F);
		// Byte lane 0 strobe low leaves the register alone
		strb = 4'hE;
		wr(8'h0C, 32'h0000_0000);
		strb = 4'hF;
		axi_rd(8'h0C);
		check(d, 32'h0000_007F);
		wr(8'h0C, 32'h0000_0000);
	endtask

	// Port D7 input functions
	task automatic t_d7();
		logic [5:0] cd [6] = '{6'h00, 6'h05, 6'h06, 6'h0A, 6'h0B, 6'h3F};
		logic [5:0] c;
		for (int k = 0; k < 6; k++) begin
			c = cd[k];
			wr(8'h00, {26'h0, c});
			for (int p = 0; p < 2; p++) begin
				set_pin(0, p[0]);
				check({t0, t6, s1, s11}, {c == 6'h05 && p[0],
					c == 6'h06 && p[0], c == 6'h0A ? p[0] : 1'b1,
					c == 6'h0B ? p[0] : 1'b1});
			end
		end
		wr(8'h00, 32'h0000_0000);
		set_pin(0, 0);
	endtask

	// Interrupt select per pin
	task automatic t_irq();
		int ln [12] = '{8, 7, 15, -1, 2, 1, 0, 5, 14, 0, 1, 2};
		for (int i = 0; i < 12; i++) begin
			set_pin(i, 1);
			wr(8'(4 * i), 32'h0000_0040);
			check(irq, ln[i] < 0 ? 0 : 1 << ln[i]);
			wr(8'(4 * i), 32'h0000_0000);
			check(irq, 16'h0000);
			set_pin(i, 0);
		end
	endtask

	// Port E3 and E4 timer, disable and trigger inputs
	task automatic t_e34();
		logic [5:0] cd [7] = '{6'h02, 6'h04, 6'h07, 6'h14, 6'h15, 6'h16,
			6'h17};
		logic [5:0] c;
		for (int k = 0; k < 2; k++)
			for (int j = 0; j < 7; j++) begin
				c = cd[j];
				wr(8'(16 + 4 * k), {26'h0, c});
				for (int p = 0; p < 2; p++) begin
					set_pin(4 + k, p[0]);
					check({tclk[k], poe_n[k], trig}, {
						c == 6'h02 ? p[0] : c == 6'h04 && !p[0],
						c == 6'h07 ? p[0] : 1'b1,
						p[0] && c[5:2] == 4'h5 ? 4'h1 << c[1:0] : 4'h0});
				end
				wr(8'(16 + 4 * k), 32'h0000_0000);
				set_pin(4 + k, 0);
			end
	endtask

	// Port E0 receive and overcurrent, then wait routing
	task automatic t_e0_wait();
		for (int c = 16; c < 18; c++) begin
			wr(8'h04, c);
			for (int p = 0; p < 2; p++) begin
				set_pin(1, p[0]);
				check({can, usb}, {c == 16 ? p[0] : 1'b1,
					c == 17 ? p[0] : 1'b1});
			end
		end
		wr(8'h04, 32'h0000_0000);
		for (int w = 0; w < 4; w++) begin
			wr(PFM_OFS_BCR1, w);
			for (int p = 0; p < 2; p++) begin
				@(posedge clk);
				p82 <= p[0];
				p96 <= !p[0];
				pin_in[1] <= p[0];
				settle();
				check({wsel, wait_n}, {w == 0 ? 3'b000 : 3'b001 << (w - 1),
					w == 0 ? 1'b1 : w == 3 ? !p[0] : p[0]});
			end
		end
		wr(PFM_OFS_BCR1, 32'h0000_0000);
	endtask

	// Comparator results driven onto pins
	task automatic t_cmp();
		int cn [5] = '{1, 0, 2, 1, 0};
		for (int i = 7; i < 12; i++) begin
			wr(8'(4 * i), 32'h0000_001E);
			for (int j = 0; j < 4; j++) begin
				@(posedge clk);
				cmp <= 3'b001 << j;
				settle();
				check({pin_oe_n[i], pin_out[i]}, {1'b0, cmp[cn[i - 7]]});
			end
			wr(8'(4 * i), 32'h0000_0000);
			check(pin_oe_n[i], 1'b1);
		end
	endtask

	// Strobe routing and bus pin controls
	task automatic t_bus();
		logic [1:0] m;
		@(posedge clk);
		bus_act <= 1;
		for (int k = 0; k < 4; k++) begin
			m = k;
			@(posedge clk);
			stb_n <= {m[1], m[0], 2'b11};
			wr(PFM_OFS_CSS, {25'h0, m[0], m, m, 1'b0, m[0]});
			check({cs0, cs1, cs2, cs3}, {2'b01 << m[0], 4'b0001 << m,
				m[1] ? 3'b100 : 3'b001 << m, 2'b01 << m[0]});
			check({pin_oe_n[8:7], pin_out[8:7] & ~pin_oe_n[8:7]},
				{m[0], !m[1], !m[0] && m[1], m[1] && m[0]});
		end
		@(posedge clk);
		bus_act <= 0;
		stb_n <= 4'hF;
		wr(PFM_OFS_CSS, 32'h0000_0000);
		wr(PFM_OFS_BCR0, 32'h0000_0037);
		check({adrl, adrh, bclk, dh, a20}, 5'h1F);
		axi_rd(PFM_OFS_BCR0);
		check(d, 32'h0000_0037);
		wr(PFM_OFS_BCR0, 32'h0000_0000);
		check({adrl, adrh, bclk, dh, a20}, 5'h00);
	endtask

	// Clock enable low freezes the pin path
	task automatic t_ce();
		wr(8'h00, 32'h0000_000A);
		@(posedge clk);
		ce <= 0;
		pin_in[0] <= 1;
		settle();
		check(s1, 1'b0);
		@(posedge clk);
		ce <= 1;
		settle();
		check(s1, 1'b1);
		wr(8'h00, 32'h0000_0000);
		set_pin(0, 0);
	endtask

	// Watchdog
	initial begin
		#2ms;
		miscompares++;
		wrap_up();
	end

	// Main sequence
	initial begin
		reset = 1; ce = 1; bus_act = 0; p82 = 1; p96 = 1;
		req = '0; pin_in = '0; cmp = '0; stb_n = 4'hF;
		repeat (6) @(posedge clk);
		reset <= 0;
		t_regs();
		t_d7();
		t_ce();
		t_irq();
		t_e34();
		t_e0_wait();
		t_cmp();
		t_bus();
		wrap_up();
	end
endmodule
